//--- ccs_pkg.sv
// Constants, field layout and carrier types of the charger control/status register bank
package ccs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 10;
  // Watchdog periods in microseconds: 0.5 s, 1 s, 8 s, 30 s
  localparam int unsigned WDT_US [4] = '{500000, 1000000, 8000000, 30000000};
  // Soft-start timeouts in microseconds: 6.25 ms up to 12 s
  localparam int unsigned SS_US [8] = '{6250, 12500, 25000, 50000, 100000, 400000,
                                        1500000, 12000000};
  // Under-current falling deglitch in microseconds: 0.01, 5, 50, 150 ms
  localparam int unsigned DG_US [4] = '{10, 5000, 50000, 150000};
  localparam int unsigned WDT_CYC_DEF [4] = '{WDT_US[0] * CLK_MHZ, WDT_US[1] * CLK_MHZ,
                                              WDT_US[2] * CLK_MHZ, WDT_US[3] * CLK_MHZ};
  localparam int unsigned SS_CYC_DEF [8] = '{SS_US[0] * CLK_MHZ, SS_US[1] * CLK_MHZ,
                                             SS_US[2] * CLK_MHZ, SS_US[3] * CLK_MHZ,
                                             SS_US[4] * CLK_MHZ, SS_US[5] * CLK_MHZ,
                                             SS_US[6] * CLK_MHZ, SS_US[7] * CLK_MHZ};
  localparam int unsigned DG_CYC_DEF [4] = '{DG_US[0] * CLK_MHZ, DG_US[1] * CLK_MHZ,
                                             DG_US[2] * CLK_MHZ, DG_US[3] * CLK_MHZ};

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTL2 = 8'h0f;
  localparam logic [7:0] ADDR_CTL3 = 8'h10;
  localparam logic [7:0] ADDR_CTL4 = 8'h11;
  localparam logic [7:0] ADDR_CTL5 = 8'h12;
  localparam logic [7:0] ADDR_STAT1 = 8'h13;
  localparam logic [7:0] ADDR_STAT2 = 8'h14;
  localparam logic [7:0] ADDR_STAT3 = 8'h15;
  localparam logic [7:0] ADDR_STAT4 = 8'h16;
  localparam logic [7:0] ADDR_STAT5 = 8'h17;

  // ----------------------------------------------------------------
  // Reset values and reset-source masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CTL2_RST = 8'h00;
  localparam logic [7:0] CTL3_RST = 8'h80;
  localparam logic [7:0] CTL4_RST = 8'h71;
  localparam logic [7:0] CTL5_RST = 8'h60;
  localparam logic [7:0] CTL2_RR_MASK = 8'hf8;
  localparam logic [7:0] CTL3_RR_MASK = 8'h1f;
  localparam logic [7:0] CTL4_RR_MASK = 8'h8c;
  localparam logic [7:0] CTL5_RR_MASK = 8'hf8;
  localparam logic [7:0] CTL2_WDT_MASK = 8'h38;
  localparam logic [7:0] CTL5_RO_MASK = 8'h03;
  localparam logic [7:0] STAT2_RSVD_MASK = 8'h13;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTL2_REG_RESET = 7;
  localparam int unsigned CTL2_HIZ = 6;
  localparam int unsigned CTL2_REV_CTL = 5;
  localparam int unsigned CTL2_CHARGE = 4;
  localparam int unsigned CTL2_BYPASS = 3;
  localparam int unsigned CTL2_DRV_OFF = 2;
  localparam int unsigned CTL2_DRV_ONE = 1;
  localparam int unsigned CTL2_DRV_TWO = 0;
  localparam int unsigned CTL3_RATE_LSB = 5;
  localparam int unsigned CTL3_WDT_LSB = 3;
  localparam int unsigned CTL3_WDT_OFF = 2;
  localparam int unsigned CTL3_OC_SEL = 1;
  localparam int unsigned CTL3_OC_OFF = 0;
  localparam int unsigned CTL4_RSNS = 7;
  localparam int unsigned CTL4_SS_LSB = 4;
  localparam int unsigned CTL4_DG_LSB = 2;
  localparam int unsigned CTL5_OVP_OFF = 7;
  localparam int unsigned CTL5_OVP_LSB = 5;
  localparam int unsigned CTL5_TRIM_LSB = 3;
  localparam int unsigned STAT1_OUTPUT_OVERVOLTAGE_THRESHOLD = 5;
  localparam int unsigned STAT2_UCP = 5;
  localparam int unsigned STAT4_ADC_DONE = 7;
  localparam int unsigned STAT4_SS_TO = 6;
  localparam int unsigned STAT4_NEAR = 5;
  localparam int unsigned STAT4_WDT = 0;
  localparam int unsigned STAT5_CONV_OC = 1;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  // Switching rate in half-kHz units: 187.5 kHz .. 1500 kHz
  localparam logic [11:0] RATE_HALF_KHZ [8] = '{12'h177, 12'h1f4, 12'h258, 12'h2ee,
                                                12'h3e8, 12'h5dc, 12'h7d0, 12'hbb8};
  localparam logic [5:0] OVP_BASE_DV = 6'h2f;   // 4.7 V in 0.1 V steps
  localparam logic [2:0] OC_COUNT_ONE = 3'h1;
  localparam logic [2:0] OC_COUNT_MANY = 3'h4;
  localparam logic [7:0] NEAR_CODES = 8'h19;    // 5 percent in 0.19531 percent steps

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] prot_one;
    logic [7:0] prot_two;
    logic [7:0] presence;
    logic [7:0] thermal;
    logic [7:0] converter;
  } ccs_status_type;

  typedef struct packed {
    logic converter_switch_en;
    logic adc_run_en;
    logic internal_regulator_en;
    logic input_driver_one_on;
    logic input_driver_two_on;
    logic bypass_mode;
    logic charge_enable;
    logic battery_sense_resistor_sel;
    logic [11:0] switch_rate_half_khz;
    logic [1:0] switch_rate_trim;
    logic [5:0] output_overvoltage_dv;
    logic converter_overcurrent_trip;
    logic watchdog_expired;
  } ccs_drive_type;

  typedef struct packed {
    logic [7:0] ctl2;
    logic [7:0] ctl3;
    logic [7:0] ctl4;
    logic [7:0] ctl5;
    logic [31:0] wdt_cnt;
    logic wdt_exp;
    logic [31:0] ss_cnt;
    logic ss_run;
    logic ss_to;
    logic [31:0] dg_cnt;
    logic ucp_dg;
    logic [2:0] oc_cnt;
    logic oc_trip;
    logic adc_done;
    logic [39:0] stat_prev;
    logic [7:0] rdata;
  } ccs_state_type;

endpackage

//--- ccs_regs.sv
// Charger control and live status register bank with watchdog and protection timing
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Writing the reset bit restores reset-tagged fields, then the bit clears itself.
// - High-impedance mode stops switching, ADC, input drivers and internal regulator.
// - In reverse power mode, host driver writes need the reverse path control bit.
// - Any fault clears charge enable; reset and watchdog clear charge and reverse control.
// - Bypass bit picks bypass over divider; cleared by reset or watchdog.
// - Force-off bit holds both input drivers off whatever their own bits say.
// - Each driver bit commands and reports its driver; host toggles to swap inputs.
// - Three-bit rate field maps to 187.5 through 1500 kHz, default 500 kHz.
// - Two-bit watchdog field selects 0.5, 1, 8 or 30 seconds.
// - Watchdog disable bit stops the watchdog; zero keeps it running.
// - Converter over-current trips after one event, or four when selected.
// - Converter over-current disable bit suppresses that protection.
// - One bit tells current measurement which battery sense resistor is fitted.
// - Soft-start timeout field sets the wait; then input current is checked.
// - Under-current protection uses a selectable falling deglitch of four lengths.
// - Output over-voltage threshold is 4.7 V plus 0.1 V per code; disable bit.
// - Rate trim field keeps nominal, raises ten percent, or lowers ten percent.
// - Read-only role field reports standalone, secondary or primary.
// - Status bits show live conditions; soft-start timeout, over-current trip, watchdog and conversion-complete hold.
// - Conversion-complete status is set by one-shot completion, zero in continuous.
// - Thermistor alarm status when either reading lies within five percent of limit.
// - Watchdog status reads one after expiry, zero in normal operation.
// - Each status rise gives an event pulse for the outside flag latch.
module ccs_regs
  import ccs_pkg::*;
#(
  parameter int unsigned WDT_CYC [4] = WDT_CYC_DEF,
  parameter int unsigned SS_CYC [8] = SS_CYC_DEF,
  parameter int unsigned DG_CYC [4] = DG_CYC_DEF
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic fault_in,
  input wire logic reverse_mode_in,
  input wire logic conv_oc_event_in,
  input wire logic conv_start_in,
  input wire logic ibus_above_ucp_in,
  input wire logic ucp_raw_in,
  input wire logic output_overvoltage_threshold_raw_in,
  input wire logic adc_oneshot_done_in,
  input wire logic adc_start_in,
  input wire logic adc_continuous_in,
  input wire logic [7:0] ts_bus_code_in,
  input wire logic [7:0] ts_bat_code_in,
  input wire logic [7:0] ts_bus_limit_in,
  input wire logic [7:0] ts_bat_limit_in,
  input wire logic [1:0] parallel_role_in,
  input wire ccs_status_type status_in,
  output ccs_drive_type drive_out,
  output logic [39:0] status_event_out
);

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  ccs_state_type state_reg;
  ccs_state_type state_next;
  ccs_status_type stat_live;
  logic [7:0] bus_gap;
  logic [7:0] bat_gap;
  logic output_overvoltage_threshold_live;
  logic fault_evt;
  logic host_access;
  logic [2:0] oc_target;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    host_access = reg_wr_in | reg_rd_in;

    // Output over-voltage condition gated by its disable bit
    // disable gating
    output_overvoltage_threshold_live = output_overvoltage_threshold_raw_in & ~state_reg.ctl5[CTL5_OVP_OFF];

    // Thermistor distance to limit
    bus_gap = (ts_bus_code_in > ts_bus_limit_in) ? ts_bus_code_in - ts_bus_limit_in
                                                 : ts_bus_limit_in - ts_bus_code_in;
    bat_gap = (ts_bat_code_in > ts_bat_limit_in) ? ts_bat_code_in - ts_bat_limit_in
                                                 : ts_bat_limit_in - ts_bat_code_in;

    // Live status image, block-owned bits merged in
    // live status
    stat_live = status_in;
    stat_live.prot_one[STAT1_OUTPUT_OVERVOLTAGE_THRESHOLD] = output_overvoltage_threshold_live;
    stat_live.prot_two = status_in.prot_two & ~STAT2_RSVD_MASK;
    stat_live.prot_two[STAT2_UCP] = state_reg.ucp_dg;
    stat_live.thermal[STAT4_ADC_DONE] = state_reg.adc_done & ~adc_continuous_in;
    stat_live.thermal[STAT4_SS_TO] = state_reg.ss_to;
    stat_live.thermal[STAT4_NEAR] = (bus_gap <= NEAR_CODES) | (bat_gap <= NEAR_CODES);
    stat_live.thermal[STAT4_WDT] = state_reg.wdt_exp;
    stat_live.converter[STAT5_CONV_OC] = state_reg.oc_trip;

    // Host writes to control registers
    if (state_reg.ctl2[CTL2_REG_RESET]) begin
      state_next.ctl2 = (state_reg.ctl2 & ~CTL2_RR_MASK) | (CTL2_RST & CTL2_RR_MASK);
      state_next.ctl3 = (state_reg.ctl3 & ~CTL3_RR_MASK) | (CTL3_RST & CTL3_RR_MASK);
      state_next.ctl4 = (state_reg.ctl4 & ~CTL4_RR_MASK) | (CTL4_RST & CTL4_RR_MASK);
      state_next.ctl5 = (state_reg.ctl5 & ~CTL5_RR_MASK) | (CTL5_RST & CTL5_RR_MASK);
    end else if (reg_wr_in) begin
      if (reg_addr_in == ADDR_CTL2) begin
        state_next.ctl2 = reg_wdata_in;
        if (reverse_mode_in && !state_reg.ctl2[CTL2_REV_CTL]) begin
          state_next.ctl2[CTL2_DRV_ONE] = state_reg.ctl2[CTL2_DRV_ONE];
          state_next.ctl2[CTL2_DRV_TWO] = state_reg.ctl2[CTL2_DRV_TWO];
        end
      end else if (reg_addr_in == ADDR_CTL3) begin
        state_next.ctl3 = reg_wdata_in;
      end else if (reg_addr_in == ADDR_CTL4) begin
        state_next.ctl4 = reg_wdata_in;
      end else if (reg_addr_in == ADDR_CTL5) begin
        state_next.ctl5 = reg_wdata_in & ~CTL5_RO_MASK;
      end
    end
    // Re-arming charge clears the over-current trip and count and the soft-start timeout
    if (state_next.ctl2[CTL2_CHARGE] && !state_reg.ctl2[CTL2_CHARGE]) begin
      state_next.oc_trip = 1'b0;
      state_next.oc_cnt = 3'h0;
      state_next.ss_to = 1'b0;
    end

    // Watchdog timer
    // access restarts count
    if (host_access || state_reg.ctl3[CTL3_WDT_OFF]) begin
      state_next.wdt_cnt = 32'h0;
      state_next.wdt_exp = 1'b0;
    end else if (!state_reg.wdt_exp) begin
      if (state_reg.wdt_cnt == WDT_CYC[state_reg.ctl3[CTL3_WDT_LSB +: 2]] - 1) begin
        state_next.wdt_exp = 1'b1;
        state_next.ctl2 = state_next.ctl2 & ~CTL2_WDT_MASK;
      end else begin
        state_next.wdt_cnt = state_reg.wdt_cnt + 32'h1;
      end
    end

    // Converter over-current event counting
    // one or four events
    oc_target = state_reg.ctl3[CTL3_OC_SEL] ? OC_COUNT_MANY : OC_COUNT_ONE;
    if (state_reg.ctl3[CTL3_OC_OFF]) begin
      state_next.oc_cnt = 3'h0;
      state_next.oc_trip = 1'b0;
    end else if (conv_oc_event_in && !state_next.oc_trip) begin
      // Count from the re-armed value so an event in the re-arm cycle counts
      state_next.oc_cnt = state_next.oc_cnt + 3'h1;
      if (state_next.oc_cnt >= oc_target) begin
        state_next.oc_trip = 1'b1;
      end
    end

    // Soft-start timeout
    if (conv_start_in) begin
      state_next.ss_run = 1'b1;
      state_next.ss_cnt = 32'h0;
      state_next.ss_to = 1'b0;
    end else if (state_reg.ss_run) begin
      if (state_reg.ss_cnt == SS_CYC[state_reg.ctl4[CTL4_SS_LSB +: 3]] - 1) begin
        state_next.ss_run = 1'b0;
        state_next.ss_to = ~ibus_above_ucp_in;
      end else begin
        state_next.ss_cnt = state_reg.ss_cnt + 32'h1;
      end
    end

    // Under-current falling deglitch
    // deglitch select
    if (!ucp_raw_in) begin
      state_next.dg_cnt = 32'h0;
      state_next.ucp_dg = 1'b0;
    end else if (!state_reg.ucp_dg) begin
      if (state_reg.dg_cnt == DG_CYC[state_reg.ctl4[CTL4_DG_LSB +: 2]] - 1) begin
        state_next.ucp_dg = 1'b1;
      end else begin
        state_next.dg_cnt = state_reg.dg_cnt + 32'h1;
      end
    end

    // Fault handling: newly raised protections, the over-voltage level and the external fault level
    fault_evt = fault_in | output_overvoltage_threshold_live | (state_next.oc_trip & ~state_reg.oc_trip) |
                (state_next.ss_to & ~state_reg.ss_to) | (state_next.ucp_dg & ~state_reg.ucp_dg);
    if (fault_evt) begin
      state_next.ctl2[CTL2_CHARGE] = 1'b0;
    end

    // Conversion-complete latch, completion wins over restart
    if (adc_oneshot_done_in && !adc_continuous_in) begin
      state_next.adc_done = 1'b1;
    end else if (adc_start_in || adc_continuous_in) begin
      state_next.adc_done = 1'b0;
    end

    // Status edge tracking
    state_next.stat_prev = stat_live;

    // Register read data
    if (reg_rd_in) begin
      if (reg_addr_in == ADDR_CTL2) begin
        state_next.rdata = state_reg.ctl2;
      end else if (reg_addr_in == ADDR_CTL3) begin
        state_next.rdata = state_reg.ctl3;
      end else if (reg_addr_in == ADDR_CTL4) begin
        state_next.rdata = state_reg.ctl4;
      end else if (reg_addr_in == ADDR_CTL5) begin
        state_next.rdata = {state_reg.ctl5[7:2], parallel_role_in};
      end else if (reg_addr_in == ADDR_STAT1) begin
        state_next.rdata = stat_live.prot_one;
      end else if (reg_addr_in == ADDR_STAT2) begin
        state_next.rdata = stat_live.prot_two;
      end else if (reg_addr_in == ADDR_STAT3) begin
        state_next.rdata = stat_live.presence;
      end else if (reg_addr_in == ADDR_STAT4) begin
        state_next.rdata = stat_live.thermal;
      end else if (reg_addr_in == ADDR_STAT5) begin
        state_next.rdata = stat_live.converter;
      end else begin
        state_next.rdata = READ_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
      state_reg.ctl2 <= CTL2_RST;
      state_reg.ctl3 <= CTL3_RST;
      state_reg.ctl4 <= CTL4_RST;
      state_reg.ctl5 <= CTL5_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Register read port and status rise pulses
  assign reg_rdata_out = state_reg.rdata;
  assign status_event_out = stat_live & ~state_reg.stat_prev;

  // Converter, ADC and regulator enables
  // high-impedance shutdown
  assign drive_out.converter_switch_en = state_reg.ctl2[CTL2_CHARGE] & ~state_reg.ctl2[CTL2_HIZ];
  assign drive_out.adc_run_en = ~state_reg.ctl2[CTL2_HIZ];
  assign drive_out.internal_regulator_en = ~state_reg.ctl2[CTL2_HIZ];
  assign drive_out.input_driver_one_on = state_reg.ctl2[CTL2_DRV_ONE] &
                                         ~state_reg.ctl2[CTL2_DRV_OFF] & ~state_reg.ctl2[CTL2_HIZ];
  assign drive_out.input_driver_two_on = state_reg.ctl2[CTL2_DRV_TWO] &
                                         ~state_reg.ctl2[CTL2_DRV_OFF] & ~state_reg.ctl2[CTL2_HIZ];
  assign drive_out.bypass_mode = state_reg.ctl2[CTL2_BYPASS];
  assign drive_out.charge_enable = state_reg.ctl2[CTL2_CHARGE];
  assign drive_out.battery_sense_resistor_sel = state_reg.ctl4[CTL4_RSNS];
  assign drive_out.switch_rate_half_khz = RATE_HALF_KHZ[state_reg.ctl3[CTL3_RATE_LSB +: 3]];
  assign drive_out.switch_rate_trim = state_reg.ctl5[CTL5_TRIM_LSB +: 2];
  // threshold in tenths of a volt
  assign drive_out.output_overvoltage_dv = OVP_BASE_DV + {4'h0, state_reg.ctl5[CTL5_OVP_LSB +: 2]};
  assign drive_out.converter_overcurrent_trip = state_reg.oc_trip;
  assign drive_out.watchdog_expired = state_reg.wdt_exp;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking ast_cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  AST_REG_RESET_RESTORES: assert property (
    state_reg.ctl2[CTL2_REG_RESET] |=> !state_reg.ctl2[CTL2_REG_RESET] &&
      state_reg.ctl3[4:0] == CTL3_RST[4:0] && state_reg.ctl2[7:3] == 5'h00)
    else $error("register reset did not restore defaults");

  AST_HIZ_SHUTDOWN: assert property (
    state_reg.ctl2[CTL2_HIZ] |-> !drive_out.converter_switch_en && !drive_out.adc_run_en &&
      !drive_out.internal_regulator_en && !drive_out.input_driver_one_on &&
      !drive_out.input_driver_two_on)
    else $error("high-impedance mode left something running");

  AST_REVERSE_REFUSED: assert property (
    reverse_mode_in && !state_reg.ctl2[CTL2_REV_CTL] && reg_wr_in &&
      reg_addr_in == ADDR_CTL2 && !state_reg.ctl2[CTL2_REG_RESET]
      |=> state_reg.ctl2[1:0] == $past(state_reg.ctl2[1:0]))
    else $error("driver write taken in reverse mode without permission");

  AST_FAULT_CLEARS_CHARGE: assert property (
    fault_in |=> !state_reg.ctl2[CTL2_CHARGE] && !drive_out.converter_switch_en)
    else $error("charge enable survived a fault");

  AST_WATCHDOG_CLEARS: assert property (
    $rose(state_reg.wdt_exp) |-> state_reg.ctl2[5:3] == 3'h0)
    else $error("watchdog expiry left control bits set");

  AST_FORCE_OFF: assert property (
    state_reg.ctl2[CTL2_DRV_OFF] |-> !drive_out.input_driver_one_on &&
      !drive_out.input_driver_two_on)
    else $error("driver on while forced off");

  AST_WATCHDOG_IDLE: assert property (
    state_reg.ctl3[CTL3_WDT_OFF] [*2] |-> state_reg.wdt_cnt == 32'h0 && !state_reg.wdt_exp)
    else $error("watchdog ran while disabled");

  AST_OC_SINGLE: assert property (
    conv_oc_event_in && !state_reg.ctl3[CTL3_OC_SEL] && !state_reg.ctl3[CTL3_OC_OFF] &&
      !state_reg.ctl2[CTL2_REG_RESET] |=> state_reg.oc_trip)
    else $error("single over-current event did not trip");

  AST_ADC_CONTINUOUS: assert property (
    adc_continuous_in |-> ##1 (!state_reg.adc_done || !adc_continuous_in))
    else $error("conversion-complete held in continuous mode");

  AST_OC_DISABLED: assert property (
    state_reg.ctl3[CTL3_OC_OFF] |=> !state_reg.oc_trip)
    else $error("over-current trip while disabled");

  AST_SS_TIMEOUT: assert property (
    $rose(state_reg.ss_to) |-> $past(state_reg.ss_run) && !$past(ibus_above_ucp_in))
    else $error("soft-start timeout without low current");

  AST_UCP_RELEASE: assert property (
    !ucp_raw_in |=> !state_reg.ucp_dg)
    else $error("under-current status held after release");

  AST_ROLE_READ: assert property (
    reg_rd_in && reg_addr_in == ADDR_CTL5 |=> reg_rdata_out[1:0] == $past(parallel_role_in))
    else $error("role field read back wrong");

  AST_ADC_DONE_SET: assert property (
    adc_oneshot_done_in && !adc_continuous_in |=> state_reg.adc_done)
    else $error("one-shot completion not reported");

  AST_EVENT_SINGLE: assert property (
    status_event_out != 40'h0 |=> (status_event_out & $past(status_event_out)) == 40'h0)
    else $error("status event longer than one cycle");

  AST_WATCHDOG_QUIET: assert property (
    $rose(state_reg.wdt_exp) |-> !$past(reg_wr_in) && !$past(reg_rd_in))
    else $error("watchdog expired after a host access");

endmodule

`default_nettype wire

//--- ccs_host.sv
// Host processor model driving the register byte port
`timescale 1ns/1ps
`default_nettype none
module ccs_host (
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in
);
  // Idle bus from time zero
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~d; // Stale data never looks valid
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    d = rdata_in;
  endtask
endmodule
`default_nettype wire

//--- tb_charger_control_status_regs.sv
// Self-checking bench for the charger control and status registers
`timescale 1ns/1ps
`default_nettype none
module tb_charger_control_status_regs import ccs_pkg::*;;
  localparam int unsigned WD [4] = '{40, 50, 60, 70};
  localparam int unsigned SS [8] = '{10, 12, 14, 16, 18, 20, 22, 24};
  localparam int unsigned DG [4] = '{3, 5, 7, 9};
  logic clk_in, rst_n_in, wr, rd, fault, oc_ev, rev, cst, ibus, ucp, ovp, adn, ast, acn;
  logic [7:0] addr, wdata, rdata, d, tsb, tst;
  logic [39:0] ev;
  logic [1:0] role;
  ccs_status_type st;
  ccs_drive_type drv;
  int err_total, total_checks, cyc;
  ccs_host h (.clk_in(clk_in), .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata),
    .rdata_in(rdata));
  ccs_regs #(.WDT_CYC(WD), .SS_CYC(SS), .DG_CYC(DG)) DUT (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .fault_in(fault), .reverse_mode_in(rev), .conv_oc_event_in(oc_ev), .conv_start_in(cst),
    .ibus_above_ucp_in(ibus), .ucp_raw_in(ucp), .output_overvoltage_threshold_raw_in(ovp),
    .adc_oneshot_done_in(adn), .adc_start_in(ast), .adc_continuous_in(acn),
    .ts_bus_code_in(tsb), .ts_bat_code_in(tst), .ts_bus_limit_in(8'h80),
    .ts_bat_limit_in(8'h80), .parallel_role_in(role), .status_in(st), .drive_out(drv),
    .status_event_out(ev));
  // Clock at 100 ns period
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      give_verdict;
    end
  end
  // Main sequence
  initial begin
    {rst_n_in, fault, oc_ev, rev, cst, ibus, ucp, ovp, adn, ast, acn} = '0;
    {role, st, tsb, tst, err_total, total_checks, cyc} = '0;
    repeat (6) @(negedge clk_in);
    rst_n_in = 1'b1;
    t_reset;
    t_drivers;
    t_watchdog;
    t_rate_prot;
    t_role;
    t_status;
    give_verdict;
  end
  // Reset values and register reset
  task automatic t_reset;
    logic [7:0] rv [4] = '{8'h00, 8'h80, 8'h71, 8'h60};
    for (int i = 0; i < 10; i++) begin
      h.rd(8'h0f + 8'(i), d);
      chk(12'(d), (i < 4) ? 12'(rv[i]) : 12'h000);
    end
    h.wr(ADDR_CTL3, 8'hff);
    h.wr(ADDR_CTL2, 8'h87);
    h.rd(ADDR_CTL3, d);
    chk(12'(d), 12'h0e0);
    h.rd(ADDR_CTL2, d);
    chk(12'(d), 12'h007);
    $display("register reset done");
  endtask
  // Driver control and fault
  task automatic t_drivers;
    logic [7:0] cv [4] = '{8'h03, 8'h43, 8'h07, 8'h01};
    logic [3:0] dv [4] = '{4'hf, 4'h0, 4'h3, 4'h7};
    for (int i = 0; i < 4; i++) begin
      h.wr(ADDR_CTL2, cv[i]);
      chk(12'({drv.input_driver_one_on, drv.input_driver_two_on, drv.adc_run_en,
        drv.internal_regulator_en}), 12'(dv[i]));
    end
    h.wr(ADDR_CTL2, 8'h18);
    @(negedge clk_in);
    fault = 1'b1;
    @(negedge clk_in);
    fault = 1'b0;
    @(negedge clk_in);
    chk(12'({drv.charge_enable, drv.bypass_mode}), 12'h001);
    $display("drivers and fault done");
  endtask
  // Watchdog periods and disable
  task automatic t_watchdog;
    for (int s = 0; s < 4; s++) begin
      h.wr(ADDR_CTL3, 8'h80 | 8'(s << 3));
      h.wr(ADDR_CTL2, 8'h38);
      repeat (WD[s] - 4) @(negedge clk_in);
      chk(12'({drv.watchdog_expired, drv.charge_enable, drv.bypass_mode}), 12'h003);
      repeat (8) @(negedge clk_in);
      chk(12'({drv.watchdog_expired, drv.charge_enable, drv.bypass_mode}), 12'h004);
      h.rd(ADDR_CTL2, d);
      chk(12'(d), 12'h000);
    end
    h.wr(ADDR_CTL3, 8'h84);
    repeat (90) @(negedge clk_in);
    chk(12'(drv.watchdog_expired), 12'h000);
    $display("watchdog done");
  endtask
  // Rate, threshold and over-current
  task automatic t_rate_prot;
    logic [11:0] hk [8] = '{375, 500, 600, 750, 1000, 1500, 2000, 3000};
    for (int i = 0; i < 8; i++) begin
      h.wr(ADDR_CTL3, 8'(i << 5) | 8'h04);
      chk(drv.switch_rate_half_khz, hk[i]);
    end
    for (int c = 0; c < 4; c++) begin
      h.wr(ADDR_CTL5, 8'(c << 5) | 8'(c << 3));
      chk(12'({drv.output_overvoltage_dv, drv.switch_rate_trim}), 12'({6'(47 + c), 2'(c)}));
    end
    h.wr(ADDR_CTL3, 8'h86);
    for (int n = 1; n <= 4; n++) begin
      @(negedge clk_in);
      oc_ev = 1'b1;
      @(negedge clk_in);
      oc_ev = 1'b0;
      chk(12'(drv.converter_overcurrent_trip), 12'(n == 4));
    end
    h.wr(ADDR_CTL3, 8'h87);
    @(negedge clk_in); // Trip clears one edge after the write lands
    chk(12'(drv.converter_overcurrent_trip), 12'h000);
    $display("rate and protection done");
  endtask
  // Reverse refusal, role and presence
  task automatic t_role;
    role = 2'b10;
    st.presence = 8'ha5;
    rev = 1'b1;
    h.wr(ADDR_CTL2, 8'h03);
    h.rd(ADDR_CTL2, d);
    chk(12'(d), 12'h000);
    h.rd(ADDR_CTL5, d);
    chk(12'(d), 12'h07a);
    h.rd(ADDR_STAT3, d);
    chk(12'(d), 12'h0a5);
    $display("role and status done");
  endtask
  // Soft-start, deglitch, ADC done, alarm and events
  task automatic t_status;
    h.wr(ADDR_CTL4, 8'h80);
    chk(12'(drv.battery_sense_resistor_sel), 12'h001);
    @(negedge clk_in);
    cst = 1'b1;
    @(negedge clk_in);
    cst = 1'b0;
    repeat (SS[0] - 1) @(negedge clk_in);
    chk(12'(ev[14]), 12'h000);
    @(negedge clk_in);
    chk(12'(ev[14]), 12'h001);
    h.rd(ADDR_STAT4, d);
    chk(12'(d), 12'h040);
    ucp = 1'b1;
    repeat (DG[0] - 1) @(negedge clk_in);
    chk(12'(ev[29]), 12'h000);
    @(negedge clk_in);
    chk(12'(ev[29]), 12'h001);
    h.rd(ADDR_STAT2, d);
    chk(12'(d), 12'h020);
    ucp = 1'b0;
    tsb = 8'h7f - NEAR_CODES;
    h.rd(ADDR_STAT4, d);
    chk(12'(d), 12'h040);
    tst = 8'h80 + NEAR_CODES;
    adn = 1'b1;
    @(negedge clk_in);
    adn = 1'b0;
    h.rd(ADDR_STAT4, d);
    chk(12'(d), 12'h0e0);
    acn = 1'b1;
    h.rd(ADDR_STAT4, d);
    chk(12'(d), 12'h060);
    $display("status done");
  endtask
endmodule
`default_nettype wire
